/* hdl/rcfa_top.sv */
// fault supervision, sync-link retry engine, buzzer and status indicators
// Behaviour
// - master sends packets with CRC and number
// - no matching reply in time: resend
// - retries spent: ack fault, stop link
// - error reply sets invalid-message fault
// - bad step order: sequence fault, hand over
// - firmware versions differ: mismatch fault
// - safety-rated with unrated peer: fault
// - link problem or standby offline: fault
// - nothing heard on field network: fault
// - user program checksum wrong: fault
// - firmware checksum wrong: fault
// - unconfigured or corrupt configuration: fault
// - tone priority fire to normal
// - buzzer sounds until acknowledge or reset
// - one acknowledge silences all alarms
// - steady pattern drives state continuously
// - alternating indicators stay opposite
// - flashing indicators flash in phase
// - combined codes off, red, alternating
// - per-channel codes off, green, flashing
// - show highest-priority fault code
`default_nettype none
module rcfa_top #(
  parameter int unsigned ACK_CYC   = rcfa_pkg::ACK_TO_CYC,
  parameter int unsigned SIL_CYC   = rcfa_pkg::SILENCE_CYC,
  parameter int unsigned SEQ_CYC   = rcfa_pkg::SEQ_WIN_CYC,
  parameter int unsigned SLOT_CYC  = rcfa_pkg::SLOT_CYC,
  parameter int unsigned FLASH_CYC = rcfa_pkg::FLASH_CYC
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // sync link to peer
  output logic             tx_tog,
  output logic      [31:0] tx_data,
  output logic      [7:0]  tx_tn,
  output logic      [7:0]  tx_crc,
  input  wire logic        rx_tog,
  input  wire logic [1:0]  rx_kind,
  input  wire logic [7:0]  rx_tn,
  input  wire logic        link_err,
  // field network backup path and panel
  input  wire logic        fb_peer_tog,
  input  wire logic        btn_ack,
  input  wire logic        btn_reset,
  // annunciation
  output logic             ctrl_takeover,
  output logic             buzzer,
  output logic             led_a_red,
  output logic             led_a_green,
  output logic             led_b_red,
  output logic             led_b_green
);
  import rcfa_pkg::*;

  logic [31:0] ctrl_r, fwver_r, peer_r, alarm_r, led_r;
  logic [F_NUM-1:0] fault_r, fset;
  logic [3:0]  code;
  rcfa_link_t  lk_r;
  logic [31:0] lk_tmr_r, sil_r, seq_tmr_r, slot_cnt_r, fl_cnt_r;
  logic [1:0]  retry_r, seq_exp_r;
  logic [2:0]  slot_r;
  logic        phase_r, buzz_r, takeover_r, buzzer_r;
  logic [31:0] txd_r;
  logic [7:0]  tn_r, crc_r;
  logic        tog_r;
  logic [1:0]  red_r, grn_r;

  // ahb slave: zero wait, read data fetched in address phase
  logic        acc, wr_pend_r;
  logic [7:0]  wa_r;
  logic [31:0] rd_val, rdata_r;
  assign acc = hsel && htrans[1] && hready;

  always_comb
  begin
    rd_val = RST_WORD;
    if (haddr[7:0] == A_CTRL) rd_val = ctrl_r;
    else if (haddr[7:0] == A_FWVER) rd_val = fwver_r;
    else if (haddr[7:0] == A_PEER) rd_val = peer_r;
    else if (haddr[7:0] == A_TX) rd_val = txd_r;
    else if (haddr[7:0] == A_FAULT) rd_val = {22'h00_0000, fault_r};
    else if (haddr[7:0] == A_CODE) rd_val = {24'h00_0000, retry_r, lk_r, code};
    else if (haddr[7:0] == A_ALARM) rd_val = alarm_r;
    else if (haddr[7:0] == A_LED) rd_val = led_r;
    else if (haddr[7:0] == A_SEQ) rd_val = {30'h0000_0000, seq_exp_r};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'h0;
      wa_r      <= 8'h00;
      rdata_r   <= RST_WORD;
    end
    else
    begin
      wr_pend_r <= acc && hwrite;
      if (acc) wa_r <= haddr[7:0];
      if (acc && !hwrite) rdata_r <= rd_val;
    end
  end

  logic w_ctrl, w_fw, w_peer, w_tx, w_flt, w_alm, w_led, w_seq;
  logic [1:0] w_csd, w_csc;
  assign w_ctrl = wr_pend_r && wa_r == A_CTRL;
  assign w_fw   = wr_pend_r && wa_r == A_FWVER;
  assign w_peer = wr_pend_r && wa_r == A_PEER;
  assign w_tx   = wr_pend_r && wa_r == A_TX;
  assign w_flt  = wr_pend_r && wa_r == A_FAULT;
  assign w_alm  = wr_pend_r && wa_r == A_ALARM;
  assign w_led  = wr_pend_r && wa_r == A_LED;
  assign w_seq  = wr_pend_r && wa_r == A_SEQ;
  assign w_csd  = {wr_pend_r && wa_r == A_FCSD, wr_pend_r && wa_r == A_UCSD};
  assign w_csc  = {wr_pend_r && wa_r == A_FCSC, wr_pend_r && wa_r == A_UCSC};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_r  <= RST_WORD;
      fwver_r <= RST_WORD;
      peer_r  <= RST_WORD;
      alarm_r <= RST_WORD;
      led_r   <= RST_WORD;
    end
    else
    begin
      if (w_ctrl) ctrl_r <= hwdata & 32'h0000_001B;
      if (w_fw) fwver_r <= {16'h0000, hwdata[15:0]};
      if (w_peer) peer_r <= {14'h0000, hwdata[17:0]};
      if (w_alm) alarm_r <= {27'h000_0000, hwdata[4:0]};
      if (w_led) led_r <= {23'h00_0000, hwdata[8:0]};
    end
  end

  // two-flop synchronisers for every sync link, field network and panel input
  logic [14:0] s1_r, s2_r;
  logic [3:0]  prev_r;
  logic        rx_ev, fb_ev, ack_ev, rst_ev;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_r   <= 15'h0000;
      s2_r   <= 15'h0000;
      prev_r <= 4'h0;
    end
    else
    begin
      s1_r   <= {rx_tog, rx_kind, rx_tn, link_err, fb_peer_tog, btn_ack, btn_reset};
      s2_r   <= s1_r;
      prev_r <= {s2_r[14], s2_r[2:0]};
    end
  end
  assign rx_ev  = s2_r[14] ^ prev_r[3];
  assign fb_ev  = s2_r[2] ^ prev_r[2];
  assign ack_ev = (s2_r[1] && !prev_r[1]) || (s2_r[0] && !prev_r[0]);

  // acknowledged packet engine
  logic rx_hit, tmo;
  assign rx_hit = rx_ev && s2_r[11:4] == tn_r;
  assign tmo    = lk_tmr_r == ACK_CYC - 1;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lk_r     <= LK_IDLE;
      lk_tmr_r <= RST_WORD;
      retry_r  <= 2'h0;
      txd_r    <= RST_WORD;
      tn_r     <= 8'h00;
      crc_r    <= 8'h00;
      tog_r    <= 1'h0;
    end
    else
    begin
      case (lk_r)
        LK_IDLE:
          if (w_tx && ctrl_r[CTL_MASTER])
          begin
            txd_r   <= hwdata;
            tn_r    <= tn_r + 8'h01;
            crc_r   <= rcfa_crc8({hwdata, tn_r + 8'h01});
            retry_r <= 2'h0;
            lk_r    <= LK_SEND;
          end
        LK_SEND:
        begin
          tog_r    <= ~tog_r;
          lk_tmr_r <= RST_WORD;
          lk_r     <= LK_WAIT;
        end
        LK_WAIT:
        begin
          lk_tmr_r <= lk_tmr_r + 32'h1;
          if (rx_hit) lk_r <= LK_IDLE;
          else if (tmo && retry_r != 2'(MAX_RETRY))
          begin
            retry_r <= retry_r + 2'h1;
            lk_r    <= LK_SEND;
          end
          else if (tmo) lk_r <= LK_DEAD;
        end
        LK_DEAD:
          if (!fault_r[F_ACK]) lk_r <= LK_IDLE;
        default: lk_r <= LK_IDLE;
      endcase
    end
  end
  assign fset[F_ACK] = lk_r == LK_WAIT && tmo && !rx_hit && retry_r == 2'(MAX_RETRY);
  assign fset[F_MSG] = lk_r == LK_WAIT && rx_hit && s2_r[13:12] == RX_ERR;

  // program flow: checkpoints in order, each within a window
  logic seq_bad;
  assign seq_bad = (w_seq && hwdata[1:0] != seq_exp_r) || seq_tmr_r == SEQ_CYC - 1;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      seq_exp_r <= 2'h0;
      seq_tmr_r <= RST_WORD;
    end
    else if (!ctrl_r[CTL_MASTER] || w_seq)
    begin
      seq_tmr_r <= RST_WORD;
      if (w_seq) seq_exp_r <= seq_exp_r + 2'h1;
    end
    else if (seq_tmr_r != SEQ_CYC - 1) seq_tmr_r <= seq_tmr_r + 32'h1;
  end
  assign fset[F_SEQ] = seq_bad && ctrl_r[CTL_MASTER];

  // running checksums: index 0 user program, 1 firmware image
  logic [31:0] cs_acc_r [2];
  logic [1:0]  cs_bad;
  for (genvar g = 0; g < 2; g++)
  begin : g_cs
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn) cs_acc_r[g] <= RST_WORD;
      else if (w_csc[g]) cs_acc_r[g] <= RST_WORD;
      else if (w_csd[g]) cs_acc_r[g] <= cs_acc_r[g] + hwdata;
    end
    assign cs_bad[g] = w_csc[g] && hwdata != cs_acc_r[g];
  end
  assign fset[F_UCS] = cs_bad[0];
  assign fset[F_FCS] = cs_bad[1];

  // peer silence on the field network
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn) sil_r <= RST_WORD;
    else if (fb_ev) sil_r <= RST_WORD;
    else if (sil_r != SIL_CYC) sil_r <= sil_r + 32'h1;
  end
  assign fset[F_SIL]  = sil_r == SIL_CYC;
  assign fset[F_CFG]  = !ctrl_r[CTL_CFG] || ctrl_r[CTL_CORRUPT];
  assign fset[F_LINK] = s2_r[3] || (ctrl_r[CTL_MASTER] && !peer_r[PEER_ONLINE]);
  assign fset[F_FWM]  = peer_r[PEER_ONLINE] && fwver_r[15:0] != peer_r[15:0];
  assign fset[F_SGM]  = peer_r[PEER_ONLINE] && ctrl_r[CTL_SAFE] && !peer_r[PEER_SAFE];

  // sticky faults, write one to clear, a new set wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn) fault_r <= '0;
    else fault_r <= (fault_r & ~(w_flt ? hwdata[F_NUM-1:0] : '0)) | fset;
  end

  always_comb
  begin
    code = 4'h0;
    for (int i = F_NUM - 1; i >= 0; i--)
      if (fault_r[i]) code = 4'(i + 1);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn) takeover_r <= 1'h0;
    else takeover_r <= fault_r[F_SEQ];
  end

  // buzzer latch, tone select and pattern
  logic [4:0] cond, cond_prev_r;
  logic [7:0] pat;
  assign cond = {alarm_r[4], alarm_r[3], alarm_r[2] || |fault_r, alarm_r[1:0]};
  always_comb
  begin
    if (cond[0]) pat = PAT_TEMPORAL;
    else if (cond[1]) pat = PAT_SUPV;
    else if (cond[2]) pat = PAT_TRBL;
    else if (cond[3] || cond[4]) pat = PAT_GAS;
    else pat = 8'h00;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cond_prev_r <= 5'h00;
      buzz_r      <= 1'h0;
    end
    else
    begin
      cond_prev_r <= cond;
      if (|(cond & ~cond_prev_r)) buzz_r <= 1'h1;
      else if (ack_ev || (w_ctrl && hwdata[CTL_ACK])) buzz_r <= 1'h0;
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      slot_cnt_r <= RST_WORD;
      slot_r     <= 3'h0;
      fl_cnt_r   <= RST_WORD;
      phase_r    <= 1'h0;
      buzzer_r   <= 1'h0;
    end
    else
    begin
      slot_cnt_r <= (slot_cnt_r == SLOT_CYC - 1) ? RST_WORD : slot_cnt_r + 32'h1;
      if (slot_cnt_r == SLOT_CYC - 1) slot_r <= slot_r + 3'h1;
      fl_cnt_r <= (fl_cnt_r == FLASH_CYC - 1) ? RST_WORD : fl_cnt_r + 32'h1;
      if (fl_cnt_r == FLASH_CYC - 1) phase_r <= ~phase_r;
      buzzer_r <= buzz_r && pat[3'h7 - slot_r];
    end
  end

  // status indicators, one shared phase, inverted for channel b in the alternating modes
  for (genvar c = 0; c < 2; c++)
  begin : g_led
    logic [2:0] chm;
    logic [1:0] rg;
    logic       ph;
    assign chm = led_r[3 * c + 5 -: 3];
    assign ph  = (c == 0) ? phase_r : ~phase_r;
    always_comb
    begin
      rg = 2'h0;
      case (led_r[2:0])
        CM_OFF: rg = 2'h0;
        CM_RED: rg = 2'h2;
        CM_ALT_RG: rg = ph ? 2'h2 : 2'h1;
        CM_ALT_RO: rg = ph ? 2'h2 : 2'h0;
        default:
          case (chm)
            CH_GREEN: rg = 2'h1;
            CH_FL_GO: rg = phase_r ? 2'h1 : 2'h0;
            CH_FL_RO: rg = phase_r ? 2'h2 : 2'h0;
            CH_FL_RG: rg = phase_r ? 2'h2 : 2'h1;
            default: rg = 2'h0;
          endcase
      endcase
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        red_r[c] <= 1'h0;
        grn_r[c] <= 1'h0;
      end
      else
      begin
        red_r[c] <= rg[1];
        grn_r[c] <= rg[0];
      end
    end
  end

  assign hrdata        = rdata_r;
  assign hreadyout     = 1'h1;
  assign hresp         = 1'h0;
  assign tx_tog        = tog_r;
  assign tx_data       = txd_r;
  assign tx_tn         = tn_r;
  assign tx_crc        = crc_r;
  assign ctrl_takeover = takeover_r;
  assign buzzer        = buzzer_r;
  assign led_a_red     = red_r[0];
  assign led_a_green   = grn_r[0];
  assign led_b_red     = red_r[1];
  assign led_b_green   = grn_r[1];

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_TX_CRC: assert property ($changed(tog_r) |-> crc_r == rcfa_crc8({txd_r, tn_r}))
    else $error("packet crc does not cover data and number");
  AST_RETRY: assert property (lk_r == LK_WAIT && tmo && !rx_hit && retry_r < 2'(MAX_RETRY)
    |=> lk_r == LK_SEND ##1 $changed(tog_r))
    else $error("timeout did not resend the packet");
  AST_DEAD: assert property (fset[F_ACK] |=> lk_r == LK_DEAD && fault_r[F_ACK])
    else $error("spent retries did not stop the link");
  AST_MSG: assert property (fset[F_MSG] |=> fault_r[F_MSG] && lk_r == LK_IDLE)
    else $error("error reply not flagged");
  AST_SEQ: assert property (fset[F_SEQ] |=> ##1 ctrl_takeover)
    else $error("sequence fault did not hand over");
  AST_FWM: assert property (fset[F_FWM] |=> fault_r[F_FWM] && code != 4'h0)
    else $error("firmware mismatch not flagged");
  AST_SIL: assert property (sil_r == SIL_CYC |=> fault_r[F_SIL])
    else $error("peer silence not flagged");
  AST_BUZ: assert property (!buzz_r |=> !buzzer)
    else $error("buzzer sounds while not latched");
  AST_ALT: assert property (led_r[2:0] == CM_ALT_RG && $stable(led_r)
    |-> led_a_red != led_b_red && led_a_green != led_b_green)
    else $error("alternating indicators not opposite");
  AST_CODE: assert property (fault_r[F_SEQ] |-> code == 4'h1)
    else $error("highest fault code wrong");

  CV_RETRY: cover property (lk_r == LK_WAIT && tmo ##1 lk_r == LK_SEND);
  CV_ACKED: cover property (lk_r == LK_WAIT && rx_hit && s2_r[13:12] == RX_ACK);
  CV_SILENCE: cover property (buzz_r && ack_ev ##1 !buzz_r);
  CV_ALT: cover property (led_r[2:0] == CM_ALT_RG && $changed(phase_r));
endmodule
`default_nettype wire

/* shared/rcfa_pkg.sv */
// constants, register map and helpers for the fault annunciator
`default_nettype none
package rcfa_pkg;
  // clock and timing
  localparam int CLK_MHZ     = 100;
  localparam int ACK_TO_US   = 200;
  localparam int ACK_TO_CYC  = ACK_TO_US * CLK_MHZ;
  localparam int MAX_RETRY   = 3;
  localparam int SILENCE_MS  = 1000;
  localparam int SILENCE_CYC = SILENCE_MS * CLK_MHZ * 1000;
  localparam int SEQ_WIN_MS  = 10;
  localparam int SEQ_WIN_CYC = SEQ_WIN_MS * CLK_MHZ * 1000;
  localparam int SLOT_MS     = 250;
  localparam int SLOT_CYC    = SLOT_MS * CLK_MHZ * 1000;
  localparam int FLASH_MS    = 500;
  localparam int FLASH_CYC   = FLASH_MS * CLK_MHZ * 1000;
  localparam int SEQ_STEPS   = 4;
  // register byte addresses
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_FWVER = 8'h04;
  localparam logic [7:0] A_PEER  = 8'h08;
  localparam logic [7:0] A_TX    = 8'h0C;
  localparam logic [7:0] A_FAULT = 8'h10;
  localparam logic [7:0] A_CODE  = 8'h14;
  localparam logic [7:0] A_ALARM = 8'h18;
  localparam logic [7:0] A_LED   = 8'h1C;
  localparam logic [7:0] A_SEQ   = 8'h20;
  localparam logic [7:0] A_UCSD  = 8'h24;
  localparam logic [7:0] A_UCSC  = 8'h28;
  localparam logic [7:0] A_FCSD  = 8'h2C;
  localparam logic [7:0] A_FCSC  = 8'h30;
  // control fields
  localparam int CTL_MASTER  = 0;
  localparam int CTL_SAFE    = 1;
  localparam int CTL_ACK     = 2;
  localparam int CTL_CFG     = 3;
  localparam int CTL_CORRUPT = 4;
  localparam int PEER_SAFE   = 16;
  localparam int PEER_ONLINE = 17;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // fault bits, lower index wins the code
  localparam int F_SEQ  = 0;
  localparam int F_FCS  = 1;
  localparam int F_UCS  = 2;
  localparam int F_CFG  = 3;
  localparam int F_ACK  = 4;
  localparam int F_MSG  = 5;
  localparam int F_LINK = 6;
  localparam int F_SIL  = 7;
  localparam int F_FWM  = 8;
  localparam int F_SGM  = 9;
  localparam int F_NUM  = 10;
  // reply kinds on the sync link
  localparam logic [1:0] RX_ACK = 2'h1;
  localparam logic [1:0] RX_ERR = 2'h2;
  localparam logic [7:0] CRC_POLY = 8'h07;
  // tone slot masks, bit 7 first
  localparam logic [7:0] PAT_TEMPORAL = 8'hA8;
  localparam logic [7:0] PAT_SUPV     = 8'hF0;
  localparam logic [7:0] PAT_TRBL     = 8'h80;
  localparam logic [7:0] PAT_GAS      = 8'hCC;
  // indicator modes
  localparam logic [2:0] CM_CHAN   = 3'h0;
  localparam logic [2:0] CM_OFF    = 3'h1;
  localparam logic [2:0] CM_RED    = 3'h2;
  localparam logic [2:0] CM_ALT_RG = 3'h3;
  localparam logic [2:0] CM_ALT_RO = 3'h4;
  localparam logic [2:0] CH_OFF    = 3'h0;
  localparam logic [2:0] CH_GREEN  = 3'h1;
  localparam logic [2:0] CH_FL_GO  = 3'h2;
  localparam logic [2:0] CH_FL_RO  = 3'h3;
  localparam logic [2:0] CH_FL_RG  = 3'h4;

  typedef enum logic [1:0] {LK_IDLE, LK_SEND, LK_WAIT, LK_DEAD} rcfa_link_t;

  function automatic logic [7:0] rcfa_crc8(input logic [39:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 39; i >= 0; i--)
      c = {c[6:0], 1'h0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
    return c;
  endfunction
endpackage
`default_nettype wire

/* tb/rcfa_peer.sv */
// behavioural peer controller on the sync link and field network
`default_nettype none
module rcfa_peer
  import rcfa_pkg::*;
(
  // clock
  input  wire logic        hclk,
  // packets from the device
  input  wire logic        tx_tog,
  input  wire logic [31:0] tx_data,
  input  wire logic [7:0]  tx_tn,
  input  wire logic [7:0]  tx_crc,
  // scenario control: 0 ack, 1 error reply, 2 silent
  input  wire logic [1:0]  mode,
  input  wire logic        fb_on,
  // replies and backup path
  output logic             rx_tog,
  output logic      [1:0]  rx_kind,
  output logic      [7:0]  rx_tn,
  output logic             fb_peer_tog,
  output logic      [31:0] last_data,
  output logic      [7:0]  pkts
);
  logic       prev;
  logic       slow;
  logic [3:0] fb_div = 4'h0;

  function automatic logic [7:0] peer_crc(input logic [39:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 39; i >= 0; i--)
      c = {c[6:0], 1'h0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  initial
  begin
    {rx_tog, rx_kind, rx_tn, last_data, pkts, prev, slow} = '0;
    forever
    begin
      @(posedge hclk);
      if ((tx_tog ^ prev) === 1'h1)
      begin
        prev = tx_tog;
        pkts <= pkts + 8'h1;
        if (mode != 2'h2 && peer_crc({tx_data, tx_tn}) === tx_crc)
        begin
          last_data <= tx_data;
          slow = !slow;
          repeat (slow ? 10 : 1) @(posedge hclk);
          rx_kind <= (mode == 2'h1) ? RX_ERR : RX_ACK;
          rx_tn <= tx_tn;
          repeat (3) @(posedge hclk);
          rx_tog <= ~rx_tog;
          repeat (4) @(posedge hclk);
          // hold time over: lines no longer carry the reply
          rx_kind <= ~rx_kind;
          rx_tn <= ~rx_tn;
        end
      end
    end
  end

  // heartbeat on the backup path
  always @(posedge hclk)
  begin
    fb_div <= fb_div + 4'h1;
    if (fb_on && fb_div == 4'h0)
      fb_peer_tog <= ~fb_peer_tog;
  end
  initial fb_peer_tog = 1'h0;
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// testbench: faults, sync link retries, buzzer and indicators
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rcfa_pkg::*;
  logic        hclk = 1'h0;
  logic        hresetn = 1'h0;
  logic        hsel = 1'h0;
  logic        hwrite = 1'h0;
  logic        link_err = 1'h0;
  logic        btn_ack = 1'h0;
  logic        btn_reset = 1'h0;
  logic        fb_on = 1'h1;
  logic [1:0]  htrans = 2'h0;
  logic [1:0]  mode = 2'h0;
  logic [2:0]  hsize = 3'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] lf = 32'h8;
  logic        hready, hreadyout, hresp, tx_tog, rx_tog, fb_tog, takeover, buzzer;
  logic        a_r, a_g, b_r, b_g;
  logic [1:0]  rx_kind;
  logic [7:0]  tx_tn, tx_crc, rx_tn, pkts, p;
  logic [31:0] hrdata, tx_data, last_data, got, x, y, v, r, m;
  logic [31:0] exp_q[$];
  int          error_cnt = 0;
  int          total_checks = 0;
  event        res_ev;
  logic [7:0]  av[8] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h06, 8'h11};
  int          be[8] = '{0, 12, 16, 4, 16, 16, 16, 12};
  logic [31:0] lw[9] = '{32'h1, 32'h2, 32'h3, 32'h4, 32'h48, 32'h90, 32'hD8, 32'h120, 32'h40};
  logic [31:0] le[9] = '{32'h0000_1000, 32'h2010_1000, 32'h2008_0000, 32'h1008_0000,
    32'h2000_1000, 32'h1000_1000, 32'h1008_1000, 32'h2008_1000, 32'h1000_0000};

  assign hready = hreadyout;
  always #5 hclk = ~hclk;

  rcfa_top #(.ACK_CYC(20), .SIL_CYC(200), .SEQ_CYC(100), .SLOT_CYC(4), .FLASH_CYC(4)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .tx_tog(tx_tog), .tx_data(tx_data),
    .tx_tn(tx_tn), .tx_crc(tx_crc), .rx_tog(rx_tog), .rx_kind(rx_kind), .rx_tn(rx_tn),
    .link_err(link_err), .fb_peer_tog(fb_tog), .btn_ack(btn_ack), .btn_reset(btn_reset),
    .ctrl_takeover(takeover), .buzzer(buzzer), .led_a_red(a_r), .led_a_green(a_g),
    .led_b_red(b_r), .led_b_green(b_g));

  rcfa_peer u_peer (
    .hclk(hclk), .tx_tog(tx_tog), .tx_data(tx_data), .tx_tn(tx_tn), .tx_crc(tx_crc),
    .mode(mode), .fb_on(fb_on), .rx_tog(rx_tog), .rx_kind(rx_kind), .rx_tn(rx_tn),
    .fb_peer_tog(fb_tog), .last_data(last_data), .pkts(pkts));

  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // results are compared by the monitor, oldest note first
  always @(res_ev)
  begin
    total_checks++;
    if (got !== exp_q.pop_front())
    begin
      error_cnt++;
      $display("[FAIL] %0t unexpected result %h", $time, got);
    end
  end

  task automatic note(input logic [31:0] e, input logic [31:0] g);
    exp_q.push_back(e);
    got = g;
    ->res_ev;
    #1;
  endtask

  task automatic edge_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'h1 || hresp !== 1'h0)
    begin
      n++;
      if (n > 50)
      begin
        error_cnt++;
        $display("[FAIL] %0t bus answer timed out", $time);
        summarize();
      end
      @(posedge hclk);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    edge_rdy();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    edge_rdy();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask

  // poll up to n reads, then note the last one
  task automatic wait_rd(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] e,
                         input int n);
    logic [31:0] q;
    for (int i = 0; i < n; i++)
    begin
      bus(1'h0, a, 32'h0, q);
      if ((q & mk) === e)
        break;
    end
    note(e, q & mk);
    if ((q & mk) !== e && n > 1)
      summarize();
  endtask

  // packs indicator on-count, a red count, equal count, buzzer count
  task automatic cnt(input int c, output logic [31:0] pk);
    int o, ar, eq, bz;
    {o, ar, eq, bz} = '0;
    repeat (c)
    begin
      @(negedge hclk);
      o += a_r + a_g + b_r + b_g;
      ar += a_r;
      eq += ({a_r, a_g} == {b_r, b_g});
      bz += buzzer;
    end
    pk = {8'(o), 8'(ar), 8'(eq), 8'(bz)};
  endtask

  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    // config fault needs one edge after release to show
    @(posedge hclk);
    wait_rd(A_FAULT, 32'h8, 32'h8, 1);
    wait_rd(A_CODE, 32'hF, 32'h4, 1);
    v = rnd() & 32'hFFFF;
    wr(A_CTRL, 32'hB);
    wr(A_FWVER, v);
    wr(A_PEER, 32'h0003_0000 | v);
    wr(A_FAULT, 32'h3FF);
    wait_rd(A_FAULT, 32'h3FE, 32'h0, 1);
    wr(A_PEER, 32'h0002_0000 | (v ^ 32'h1));
    wait_rd(A_FAULT, 32'h300, 32'h300, 4);
    wr(A_PEER, 32'h0003_0000 | v);
    link_err <= 1'h1;
    wait_rd(A_FAULT, 32'h40, 32'h40, 8);
    link_err <= 1'h0;
    wr(A_PEER, 32'h0001_0000 | v);
    wr(A_FAULT, 32'h3FF);
    wait_rd(A_FAULT, 32'h40, 32'h40, 8);
    wr(A_PEER, 32'h0003_0000 | v);
    wr(A_FAULT, 32'h3FF);
    wait_rd(A_FAULT, 32'h3C0, 32'h0, 1);
    fb_on <= 1'h0;
    wait_rd(A_FAULT, 32'h80, 32'h80, 200);
    fb_on <= 1'h1;
    for (int k = 0; k < 2; k++)
    begin
      x = rnd();
      y = rnd();
      m = k ? 32'h2 : 32'h4;
      wr(A_FAULT, 32'h3FF);
      wr(k ? A_FCSD : A_UCSD, x);
      wr(k ? A_FCSD : A_UCSD, y);
      wr(k ? A_FCSC : A_UCSC, x + y);
      wait_rd(A_FAULT, m, 32'h0, 1);
      wr(k ? A_FCSD : A_UCSD, x);
      wr(k ? A_FCSC : A_UCSC, x + 32'h1);
      wait_rd(A_FAULT, m, m, 4);
    end
    $display("test faults done");
    for (int j = 0; j < 2; j++)
    begin
      p = pkts;
      x = rnd();
      wr(A_TX, x);
      wait_rd(A_CODE, 32'h30, 32'h20, 8);
      wait_rd(A_CODE, 32'h30, 32'h0, 30);
      note({24'h0, p + 8'h1}, {24'h0, pkts});
      note(x, last_data);
      wait_rd(A_FAULT, 32'h30, 32'h0, 1);
    end
    mode <= 2'h1;
    wr(A_TX, rnd());
    wait_rd(A_FAULT, 32'h20, 32'h20, 30);
    mode <= 2'h2;
    p = pkts;
    wr(A_TX, rnd());
    wait_rd(A_CODE, 32'hF0, 32'hF0, 100);
    wait_rd(A_FAULT, 32'h10, 32'h10, 1);
    note({24'h0, p + 8'h4}, {24'h0, pkts});
    wr(A_TX, rnd());
    repeat (40) @(posedge hclk);
    note({24'h0, p + 8'h4}, {24'h0, pkts});
    mode <= 2'h0;
    wr(A_FAULT, 32'h3FF);
    wait_rd(A_CODE, 32'h30, 32'h0, 4);
    $display("test link done");
    bus(1'h0, A_SEQ, 32'h0, r);
    // restart the checkpoint window, it ran out long ago
    wr(A_CTRL, 32'hA);
    wr(A_CTRL, 32'hB);
    wr(A_FAULT, 32'h3FF);
    for (int i = 0; i < 4; i++)
      wr(A_SEQ, {30'h0, r[1:0] + 2'(i)});
    wait_rd(A_FAULT, 32'h1, 32'h0, 1);
    wr(A_SEQ, {30'h0, r[1:0] + 2'h2});
    wait_rd(A_FAULT, 32'h1, 32'h1, 4);
    repeat (3) @(posedge hclk);
    note(32'h1, {31'h0, takeover});
    wr(A_FAULT, 32'h3FF);
    wait_rd(A_FAULT, 32'h1, 32'h1, 100);
    wr(A_CTRL, 32'hA);
    wr(A_FAULT, 32'h3FF);
    $display("test sequence done");
    for (int i = 0; i < 8; i++)
    begin
      wr(A_ALARM, 32'h0);
      btn_reset <= 1'h1;
      repeat (6) @(posedge hclk);
      btn_reset <= 1'h0;
      repeat (6) @(posedge hclk);
      wr(A_ALARM, {24'h0, av[i]});
      repeat (8) @(posedge hclk);
      cnt(32, r);
      note(be[i], r & 32'hFF);
    end
    btn_ack <= 1'h1;
    repeat (6) @(posedge hclk);
    btn_ack <= 1'h0;
    repeat (6) @(posedge hclk);
    cnt(32, r);
    note(32'h0, r & 32'hFF);
    // software acknowledge through the control word
    wr(A_ALARM, 32'h0);
    wr(A_ALARM, 32'h4);
    wr(A_CTRL, 32'hE);
    repeat (2) @(posedge hclk);
    cnt(32, r);
    note(32'h0, r & 32'hFF);
    $display("test buzzer done");
    for (int i = 0; i < 9; i++)
    begin
      wr(A_LED, lw[i]);
      repeat (4) @(posedge hclk);
      cnt(16, r);
      note(le[i], r & 32'hFFFF_FF00);
    end
    $display("test indicators done");
    summarize();
  end
endmodule
`default_nettype wire
